// file: rtl/ssp_pkg.sv
// shared constants and types of the smart switch pwm control core
package ssp_pkg;
  // channel counts and widths
  localparam int NCH = 5;
  localparam int NDI = 4;
  localparam int CNT_W = 8;
  localparam int DUTY_W = 9;
  // duty scale: 0 off, 256 fully on
  localparam logic [8:0] DUTY_OFF = 9'h000;
  localparam logic [8:0] DUTY_FULL = 9'h100;
  // shortest pulse or gap the output stage can shape, in steps
  localparam logic [8:0] SKIP_MIN = 9'h004;
  localparam logic [7:0] CNT_LAST = 8'hff;
  localparam logic [7:0] HALF_PER = 8'h80;
  // phase offsets in period steps
  localparam logic [7:0] PH_OFS_0 = 8'h00;
  localparam logic [7:0] PH_OFS_90 = 8'h40;
  localparam logic [7:0] PH_OFS_180 = 8'h80;
  localparam logic [7:0] PH_OFS_270 = 8'hc0;
  // watchdog timeouts
  localparam int CLK_KHZ = 250000;
  localparam int WD_SHORT_MS = 32;
  localparam int WD_LONG_MS = 128;
  localparam int WD_SHORT_CYC = WD_SHORT_MS * CLK_KHZ;
  localparam int WD_LONG_CYC = WD_LONG_MS * CLK_KHZ;
  localparam int WD_CNT_W = 25;
  // overtemperature warning thresholds in degrees c
  localparam logic [7:0] OT_LOW_C = 8'h73;
  localparam logic [7:0] OT_HIGH_C = 8'h87;
  // readback address that single-read mode falls back to
  localparam logic [3:0] RB_QUICK = 4'h0;
  // ballast support channel masks
  localparam logic [4:0] BAL_MASK_ALL = 5'h1f;
  localparam logic [4:0] BAL_MASK_CH3 = 5'h04;
  localparam logic [4:0] BAL_MASK_CH34 = 5'h0c;
  localparam logic [4:0] BAL_MASK_NONE = 5'h00;
  typedef enum logic [0:0] {
    MODE_NORMAL = 1'b0,
    MODE_FAIL = 1'b1
  } ssp_mode_t;
  typedef enum logic [1:0] {
    SYNC_OFF = 2'b00,
    SYNC_VALID = 2'b01,
    SYNC_TRIG0 = 2'b10,
    SYNC_TRIG_HALF = 2'b11
  } ssp_sync_t;
  typedef enum logic [2:0] {
    FB_CH1 = 3'b000,
    FB_CH2 = 3'b001,
    FB_CH3 = 3'b010,
    FB_CH4 = 3'b011,
    FB_CH5 = 3'b100,
    FB_VBAT = 3'b101,
    FB_TEMP = 3'b110
  } ssp_fb_t;
  typedef enum logic [1:0] {
    BAL_ALL = 2'b00,
    BAL_CH3 = 2'b01,
    BAL_CH34 = 2'b10,
    BAL_NONE = 2'b11
  } ssp_bal_t;
  typedef enum logic [1:0] {
    OCW_DEFAULT = 2'b00,
    OCW_THERMAL = 2'b01,
    OCW_TRANSIENT = 2'b10,
    OCW_BOTH = 2'b11
  } ssp_ocw_t;
endpackage

// file: rtl/ssp_sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ssp_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // asynchronous inputs and their synchronised copy
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;

  // first stage feeds only the second
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= i_d;
      s2_r <= s1_r;
    end
  end

  assign o_q = s2_r;
endmodule

// file: rtl/ssp_chan.sv
// one pwm output channel: phase, applied duty and pulse skipping
`timescale 1ns/1ps
module ssp_chan (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_clr,
  // period timing
  input wire logic i_tick,
  input wire logic [ssp_pkg::CNT_W-1:0] i_base,
  // channel setup
  input wire logic [1:0] i_phase,
  input wire logic [ssp_pkg::DUTY_W-1:0] i_duty,
  input wire logic i_skip_en,
  // channel state
  output logic o_on,
  output logic [ssp_pkg::CNT_W-1:0] o_cnt,
  output logic [ssp_pkg::DUTY_W-1:0] o_duty
);
  import ssp_pkg::*;

  logic [CNT_W-1:0] cnt_r, cnt_nxt, ofs;
  logic [DUTY_W-1:0] duty_r, duty_nxt, acc_r, acc_nxt, gap, sum;
  logic on_r, on_nxt, pstart;

  // duty is taken only at the channel's own period start, so a new
  // value never cuts a running pulse short
  always_comb begin
    // R19 phase offset
    unique case (i_phase)
      2'b00: ofs = PH_OFS_0;
      2'b01: ofs = PH_OFS_90;
      2'b10: ofs = PH_OFS_180;
      2'b11: ofs = PH_OFS_270;
    endcase
    cnt_nxt = i_base + ofs;
    pstart = i_tick && (cnt_r == CNT_LAST);
    gap = DUTY_FULL - i_duty;
    sum = DUTY_OFF;
    duty_nxt = duty_r;
    acc_nxt = acc_r;
    if (pstart) begin
      // R20 skip pulses near 0 percent
      if (i_skip_en && i_duty != DUTY_OFF && i_duty < SKIP_MIN) begin
        sum = acc_r + i_duty;
        duty_nxt = (sum >= SKIP_MIN) ? SKIP_MIN : DUTY_OFF;
        acc_nxt = (sum >= SKIP_MIN) ? sum - SKIP_MIN : sum;
      // R20 skip gaps near 100 percent
      end else if (i_skip_en && i_duty < DUTY_FULL && gap < SKIP_MIN)
      begin
        sum = acc_r + gap;
        duty_nxt = (sum >= SKIP_MIN) ? DUTY_FULL - SKIP_MIN : DUTY_FULL;
        acc_nxt = (sum >= SKIP_MIN) ? sum - SKIP_MIN : sum;
      end else begin
        duty_nxt = i_duty;
        acc_nxt = DUTY_OFF;
      end
    end
    // R21 R22 on while count below duty
    on_nxt = ({1'b0, cnt_r} < duty_r);
    if (i_clr) begin
      duty_nxt = DUTY_OFF;
      acc_nxt = DUTY_OFF;
      on_nxt = 1'b0;
    end
  end

  // channel registers
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cnt_r <= PH_OFS_0;
      duty_r <= DUTY_OFF;
      acc_r <= DUTY_OFF;
      on_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      duty_r <= duty_nxt;
      acc_r <= acc_nxt;
      on_r <= on_nxt;
    end
  end

  assign o_on = on_r;
  assign o_cnt = cnt_r;
  assign o_duty = duty_r;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  property p_full_on;
    duty_r == DUTY_FULL && !i_clr |=> o_on;
  endproperty
  a_full_on: assert property (p_full_on) // R21
    else $error("full duty did not switch the channel on");

  property p_zero_off;
    duty_r == DUTY_OFF |=> !o_on;
  endproperty
  a_zero_off: assert property (p_zero_off) // R21
    else $error("zero duty left the channel on");
endmodule

// file: rtl/ssp_core.sv
// digital control core of a five-channel high-side switch
// Contract
// R01: parallel topology: shared lines, separate selects
// R02: daisy chain: data out feeds next, one select
// R03: pin low sleeps; high initialises and enables
// R04: reference clock divided by 256 per period
// R05: toggle bit must invert each message
// R06: watchdog timeout selectable 32 ms or 128 ms
// R07: communication error switches to fail mode
// R08: fail: direct inputs drive; normal: pwm duty
// R09: sync strobe off high; valid low when valid
// R10: trigger-0: low once valid, high until period
// R11: trigger-half: low from sense pulse middle
// R12: feedback selector with seven sources
// R13: single-read: selection used once, then quick
// R14: all-reads: selection kept until reprogrammed
// R15: overtemperature warning threshold 115 or 135
// R16: ballast support channel mask, four selections
// R17: inrush window level mode, four settings
// R18: global duty replaces only the duty
// R19: per channel phase offset, four choices
// R20: pulse skipping interpolates near 0 and 100
// R21: duty 0 off, 256 fully on
// R22: on while phase counter below applied duty
`timescale 1ns/1ps
module ssp_core #(
  parameter int WD_SHORT_CYCLES = ssp_pkg::WD_SHORT_CYC,
  parameter int WD_LONG_CYCLES = ssp_pkg::WD_LONG_CYC
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // device pins
  input wire logic i_reset_sleep_pin_n,
  input wire logic i_ref_clk,
  input wire logic i_direct_input_1,
  input wire logic i_direct_input_2,
  input wire logic i_direct_input_3,
  input wire logic i_direct_input_4,
  // message framing from the serial front end
  input wire logic i_msg_stb,
  input wire logic i_watchdog_toggle_bit,
  input wire logic i_rb_wr,
  input wire logic [3:0] i_rb_sel,
  input wire logic i_rb_rd,
  // configuration
  input wire logic i_wd_long,
  input wire logic i_readback_persistence_mode,
  input wire logic [ssp_pkg::NCH-1:0] i_out_en,
  input wire logic [ssp_pkg::NCH-1:0] i_glob_sel,
  input wire logic [ssp_pkg::DUTY_W-1:0] i_glob_duty,
  input wire logic [ssp_pkg::NCH*ssp_pkg::DUTY_W-1:0] i_duty,
  input wire logic [2*ssp_pkg::NCH-1:0] i_phase,
  input wire logic [ssp_pkg::NCH-1:0] i_skip_en,
  input wire logic [2:0] i_fb_sel,
  input wire logic [1:0] i_sync_mode,
  input wire logic i_ot_high,
  input wire logic [7:0] i_die_temp,
  input wire logic [1:0] i_ballast_startup_support,
  input wire logic [1:0] i_inrush_overcurrent_window,
  // outputs and status
  output logic [ssp_pkg::NCH-1:0] o_out,
  output logic o_fail_mode,
  output logic o_spi_fault,
  output logic o_sleep,
  output logic [2:0] o_sense_feedback_sel,
  output logic o_sense_sync_strobe_n,
  output logic [3:0] o_rb_addr,
  output logic o_ot_warn,
  output logic [ssp_pkg::NCH-1:0] o_ballast_en,
  output logic o_ocw_temp_dep,
  output logic o_ocw_volt_dep
);
  import ssp_pkg::*;

  logic [5:0] pin_s;
  logic [NDI-1:0] di_s;
  logic ref_s, rst_pin_s;
  logic ref_d_r, ref_d_nxt, asleep_r, asleep_nxt, tick, pstart;
  logic [CNT_W-1:0] base_r, base_nxt;
  ssp_mode_t mode_r, mode_nxt;
  logic fault_r, fault_nxt, wd_last_r, wd_last_nxt;
  logic [WD_CNT_W-1:0] wd_cnt_r, wd_cnt_nxt, wd_lim;
  logic [3:0] rb_r, rb_nxt;
  logic [NCH-1:0] out_r, out_nxt, bal_r, bal_nxt, on_w;
  ssp_fb_t fb_r, fb_nxt;
  logic ot_r, ot_nxt, ocw_t_r, ocw_t_nxt, ocw_v_r, ocw_v_nxt;
  logic valid, half, is_ch;
  logic [2:0] sel;
  logic valid_d_r, armed_r, armed_nxt, sync_r, sync_nxt;
  logic [CNT_W-1:0] cnt_w [NCH];
  logic [DUTY_W-1:0] duty_w [NCH];

  // all pins pass two flops before use
  ssp_sync2 #(.W(6)) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_d({i_ref_clk, i_reset_sleep_pin_n, i_direct_input_4,
          i_direct_input_3, i_direct_input_2, i_direct_input_1}),
    .o_q(pin_s)
  );
  assign ref_s = pin_s[5];
  assign rst_pin_s = pin_s[4];
  assign di_s = pin_s[3:0];

  // reference edge, period counter and sleep
  always_comb begin
    tick = ref_s && !ref_d_r;
    ref_d_nxt = ref_s;
    // R03 sleep while pin low
    asleep_nxt = !rst_pin_s;
    // R04 divide reference by 256
    base_nxt = tick ? base_r + 8'h01 : base_r;
    pstart = tick && (base_r == CNT_LAST);
    if (asleep_r) begin
      base_nxt = CNT_LAST;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ref_d_r <= 1'b0;
      asleep_r <= 1'b1;
      base_r <= CNT_LAST;
    end else begin
      ref_d_r <= ref_d_nxt;
      asleep_r <= asleep_nxt;
      base_r <= base_nxt;
    end
  end

  // pwm channels; global duty swaps only the duty source
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic [DUTY_W-1:0] duty_sel;
    // R18 global duty selection
    assign duty_sel = i_glob_sel[g] ? i_glob_duty
                                    : i_duty[g*DUTY_W +: DUTY_W];
    ssp_chan u_chan (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_clr(asleep_r),
      .i_tick(tick),
      .i_base(base_r),
      .i_phase(i_phase[2*g +: 2]),
      .i_duty(duty_sel),
      .i_skip_en(i_skip_en[g]),
      .o_on(on_w[g]),
      .o_cnt(cnt_w[g]),
      .o_duty(duty_w[g])
    );
  end

  // watchdog and operating mode; fault holds until sleep
  always_comb begin
    // R06 short or long timeout
    wd_lim = i_wd_long ? WD_CNT_W'(WD_LONG_CYCLES - 1)
                       : WD_CNT_W'(WD_SHORT_CYCLES - 1);
    mode_nxt = mode_r;
    fault_nxt = fault_r;
    wd_last_nxt = wd_last_r;
    wd_cnt_nxt = wd_cnt_r;
    if (asleep_r) begin
      mode_nxt = MODE_NORMAL;
      fault_nxt = 1'b0;
      wd_last_nxt = 1'b0;
      wd_cnt_nxt = '0;
    end else begin
      unique case (mode_r)
        MODE_NORMAL: begin
          if (i_msg_stb) begin
            // R05 R07 missing toggle is a fault
            if (i_watchdog_toggle_bit == wd_last_r) begin
              fault_nxt = 1'b1;
              mode_nxt = MODE_FAIL;
            end
            wd_last_nxt = i_watchdog_toggle_bit;
            wd_cnt_nxt = '0;
          // R06 R07 timeout expiry is a fault
          end else if (wd_cnt_r >= wd_lim) begin
            fault_nxt = 1'b1;
            mode_nxt = MODE_FAIL;
          end else begin
            wd_cnt_nxt = wd_cnt_r + 1'b1;
          end
        end
        MODE_FAIL: begin
          wd_cnt_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      mode_r <= MODE_NORMAL;
      fault_r <= 1'b0;
      wd_last_r <= 1'b0;
      wd_cnt_r <= '0;
    end else begin
      mode_r <= mode_nxt;
      fault_r <= fault_nxt;
      wd_last_r <= wd_last_nxt;
      wd_cnt_r <= wd_cnt_nxt;
    end
  end

  // readback address; a new selection beats a same-cycle read
  always_comb begin
    rb_nxt = rb_r;
    if (asleep_r) begin
      rb_nxt = RB_QUICK;
    end else if (i_rb_wr) begin
      rb_nxt = i_rb_sel;
    // R13 R14 persistence after a read
    end else if (i_rb_rd && !i_readback_persistence_mode) begin
      rb_nxt = RB_QUICK;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rb_r <= RB_QUICK;
    end else begin
      rb_r <= rb_nxt;
    end
  end

  // outputs, feedback selection and protection settings
  always_comb begin
    out_nxt = '0;
    if (!asleep_r) begin
      // R08 fail: direct pins, normal: pwm
      if (mode_r == MODE_FAIL) begin
        out_nxt = {1'b0, di_s};
      end else begin
        out_nxt = i_out_en & on_w;
      end
    end
    // R12 illegal code keeps the last source
    fb_nxt = fb_r;
    if (i_fb_sel <= FB_TEMP) begin
      fb_nxt = ssp_fb_t'(i_fb_sel);
    end
    // R15 warning only, outputs untouched
    ot_nxt = i_die_temp > (i_ot_high ? OT_HIGH_C : OT_LOW_C);
    // R16 ballast support mask
    unique case (ssp_bal_t'(i_ballast_startup_support))
      BAL_ALL: bal_nxt = BAL_MASK_ALL;
      BAL_CH3: bal_nxt = BAL_MASK_CH3;
      BAL_CH34: bal_nxt = BAL_MASK_CH34;
      BAL_NONE: bal_nxt = BAL_MASK_NONE;
    endcase
    // R17 inrush window level mode
    ocw_t_nxt = (i_inrush_overcurrent_window == OCW_THERMAL) ||
                (i_inrush_overcurrent_window == OCW_BOTH);
    ocw_v_nxt = (i_inrush_overcurrent_window == OCW_TRANSIENT) ||
                (i_inrush_overcurrent_window == OCW_BOTH);
    if (asleep_r) begin
      fb_nxt = FB_CH1;
      ot_nxt = 1'b0;
      bal_nxt = BAL_MASK_NONE;
      ocw_t_nxt = 1'b0;
      ocw_v_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      out_r <= '0;
      fb_r <= FB_CH1;
      ot_r <= 1'b0;
      bal_r <= BAL_MASK_NONE;
      ocw_t_r <= 1'b0;
      ocw_v_r <= 1'b0;
    end else begin
      out_r <= out_nxt;
      fb_r <= fb_nxt;
      ot_r <= ot_nxt;
      bal_r <= bal_nxt;
      ocw_t_r <= ocw_t_nxt;
      ocw_v_r <= ocw_v_nxt;
    end
  end

  // sense validity and sync strobe; sensing works only in normal
  // mode, and supply or temperature sources count as always valid
  always_comb begin
    is_ch = fb_r <= FB_CH5;
    sel = is_ch ? fb_r : FB_CH1;
    valid = !asleep_r && mode_r == MODE_NORMAL && (!is_ch || on_w[sel]);
    half = is_ch ? ({1'b0, cnt_w[sel]} >= (duty_w[sel] >> 1))
                 : (base_r >= HALF_PER);
    // R10 arm at period start, disarm as valid ends
    armed_nxt = armed_r;
    if (pstart || asleep_r) begin
      armed_nxt = 1'b1;
    end else if (valid_d_r && !valid) begin
      armed_nxt = 1'b0;
    end
    unique case (ssp_sync_t'(i_sync_mode))
      // R09 off high, valid low
      SYNC_OFF: sync_nxt = 1'b1;
      SYNC_VALID: sync_nxt = !valid;
      // R10 first valid window only
      SYNC_TRIG0: sync_nxt = !(valid && armed_r);
      // R11 second half of sense pulse
      SYNC_TRIG_HALF: sync_nxt = !(valid && half);
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      valid_d_r <= 1'b0;
      armed_r <= 1'b1;
      sync_r <= 1'b1;
    end else begin
      valid_d_r <= valid;
      armed_r <= armed_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign o_out = out_r;
  assign o_fail_mode = (mode_r == MODE_FAIL);
  assign o_spi_fault = fault_r;
  assign o_sleep = asleep_r;
  assign o_sense_feedback_sel = fb_r;
  assign o_sense_sync_strobe_n = sync_r;
  assign o_rb_addr = rb_r;
  assign o_ot_warn = ot_r;
  assign o_ballast_en = bal_r;
  assign o_ocw_temp_dep = ocw_t_r;
  assign o_ocw_volt_dep = ocw_v_r;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  sequence s_bad_msg;
    !asleep_r && mode_r == MODE_NORMAL && i_msg_stb &&
    i_watchdog_toggle_bit == wd_last_r;
  endsequence
  sequence s_rd_only;
    !asleep_r && i_rb_rd && !i_rb_wr;
  endsequence

  property p_sleep_off;
    asleep_r |=> o_out == '0 && !o_fail_mode && !o_spi_fault;
  endproperty
  a_sleep_off: assert property (p_sleep_off) // R03
    else $error("outputs or fault active while asleep");

  property p_no_toggle;
    s_bad_msg |=> o_fail_mode && o_spi_fault ##1 o_out[NCH-1] == 1'b0;
  endproperty
  a_no_toggle: assert property (p_no_toggle) // R05
    else $error("untoggled message did not enter fail mode");

  property p_timeout;
    !asleep_r && mode_r == MODE_NORMAL && !i_msg_stb &&
    wd_cnt_r == wd_lim |=> o_fail_mode;
  endproperty
  a_timeout: assert property (p_timeout) // R06
    else $error("watchdog expiry did not enter fail mode");

  property p_fail_direct;
    !asleep_r && mode_r == MODE_FAIL |=> o_out == {1'b0, $past(di_s)};
  endproperty
  a_fail_direct: assert property (p_fail_direct) // R08
    else $error("fail mode output differs from direct inputs");

  property p_sync_off;
    i_sync_mode == SYNC_OFF |=> o_sense_sync_strobe_n;
  endproperty
  a_sync_off: assert property (p_sync_off) // R09
    else $error("sync strobe active while synchronisation off");

  property p_sync_valid;
    i_sync_mode == SYNC_VALID && valid |=> !o_sense_sync_strobe_n;
  endproperty
  a_sync_valid: assert property (p_sync_valid) // R09
    else $error("sync strobe high while sense valid");

  property p_trig0_hold;
    i_sync_mode == SYNC_TRIG0 && !armed_r |=> o_sense_sync_strobe_n;
  endproperty
  a_trig0_hold: assert property (p_trig0_hold) // R10
    else $error("trigger-0 strobe low before next period");

  property p_rb_single;
    s_rd_only ##0 !i_readback_persistence_mode |=> o_rb_addr == RB_QUICK;
  endproperty
  a_rb_single: assert property (p_rb_single) // R13
    else $error("single-read selection survived a read");

  property p_rb_all;
    s_rd_only ##0 i_readback_persistence_mode |=> $stable(o_rb_addr);
  endproperty
  a_rb_all: assert property (p_rb_all) // R14
    else $error("all-reads selection changed on a read");
endmodule

// file: dv/ssp_host.sv
// host side model: reference pwm clock and watchdog feeding messages
`timescale 1ns/1ps
module ssp_host #(
  parameter int HALF = 8
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // bench control
  input wire logic i_awake,
  input wire logic i_feed,
  input wire logic i_bad,
  // towards the core
  output logic o_ref_clk,
  output logic o_msg_stb,
  output logic o_toggle
);
  logic [7:0] rc_r, rc_nxt, mc_r, mc_nxt;
  logic ref_r, ref_nxt, stb_nxt, tog_r, tog_nxt;
  // toggle inverted unless told to break it
  // one device: its own select, or a chain of one
  always_comb begin
    rc_nxt = (rc_r == 8'(HALF - 1)) ? 8'h00 : rc_r + 8'h01;
    ref_nxt = (rc_r == 8'(HALF - 1)) ? ~ref_r : ref_r;
    mc_nxt = mc_r + 8'h01;
    stb_nxt = i_feed && i_awake && (mc_r[4:0] == 5'h1f);
    tog_nxt = tog_r;
    if (stb_nxt && !i_bad) begin
      tog_nxt = ~tog_r;
    end
    // the core forgets the last bit while asleep
    if (!i_awake) begin
      tog_nxt = 1'b0;
    end
  end
  // registers only
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rc_r <= 8'h00;
      ref_r <= 1'b0;
      mc_r <= 8'h00;
      o_msg_stb <= 1'b0;
      tog_r <= 1'b0;
    end else begin
      rc_r <= rc_nxt;
      ref_r <= ref_nxt;
      mc_r <= mc_nxt;
      o_msg_stb <= stb_nxt;
      tog_r <= tog_nxt;
    end
  end
  assign o_ref_clk = ref_r;
  assign o_toggle = tog_r;
endmodule

// file: dv/test_smart_switch_pwm_control.sv
// self-checking bench of the pwm control core
`timescale 1ns/1ps
module test_smart_switch_pwm_control;
  import ssp_pkg::*;
  logic i_mclk, i_rst, pin_n, ref_clk, stb, tog, feed, bad;
  logic rb_wr, rb_rd, wd_long, rb_mode, ot_high, fail, fault, sleep;
  logic strb_n, ot_warn, ocw_t, ocw_v;
  logic [3:0] di, rb_sel, rb_addr;
  logic [4:0] glob_sel, o_out, bal, skip;
  logic [8:0] glob, d0;
  logic [1:0] sync, bsel, ocw;
  logic [2:0] fb, fbs;
  logic [7:0] temp;
  int bad_count = 0;
  int cmp_count = 0;
  ssp_core #(.WD_SHORT_CYCLES(64), .WD_LONG_CYCLES(256)) i_ssp_core (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_reset_sleep_pin_n(pin_n),
    .i_ref_clk(ref_clk), .i_direct_input_1(di[0]),
    .i_direct_input_2(di[1]), .i_direct_input_3(di[2]),
    .i_direct_input_4(di[3]), .i_msg_stb(stb),
    .i_watchdog_toggle_bit(tog), .i_rb_wr(rb_wr), .i_rb_sel(rb_sel),
    .i_rb_rd(rb_rd), .i_wd_long(wd_long),
    .i_readback_persistence_mode(rb_mode), .i_out_en(5'h1f),
    .i_glob_sel(glob_sel), .i_glob_duty(glob),
    .i_duty({27'h0, 9'h080, d0}), .i_phase(10'h008), .i_skip_en(skip),
    .i_fb_sel(fb), .i_sync_mode(sync), .i_ot_high(ot_high),
    .i_die_temp(temp), .i_ballast_startup_support(bsel),
    .i_inrush_overcurrent_window(ocw), .o_out(o_out),
    .o_fail_mode(fail), .o_spi_fault(fault), .o_sleep(sleep),
    .o_sense_feedback_sel(fbs), .o_sense_sync_strobe_n(strb_n),
    .o_rb_addr(rb_addr), .o_ot_warn(ot_warn), .o_ballast_en(bal),
    .o_ocw_temp_dep(ocw_t), .o_ocw_volt_dep(ocw_v));
  ssp_host i_ssp_host (.i_mclk(i_mclk), .i_rst(i_rst), .i_awake(!sleep),
    .i_feed(feed), .i_bad(bad), .o_ref_clk(ref_clk), .o_msg_stb(stb),
    .o_toggle(tog));
  // 250 mhz system clock
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  task automatic chk(input string nm, input logic [8:0] e, g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic final_report();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // inputs move 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic t_rb(input logic m);
    rb_mode = m;
    rb_sel = 4'h5;
    rb_wr = 1'b1;
    step(1);
    rb_wr = 1'b0;
    chk("rb_addr", 9'h005, 9'(rb_addr));
    repeat (2) begin
      rb_rd = 1'b1;
      step(1);
      rb_rd = 1'b0;
      chk("rb_addr", m ? 9'h005 : 9'(RB_QUICK), 9'(rb_addr));
    end
  endtask
  task automatic t_cfg();
    logic [4:0] mask [4];
    mask = '{BAL_MASK_ALL, BAL_MASK_CH3, BAL_MASK_CH34, BAL_MASK_NONE};
    for (int k = 0; k < 7; k++) begin
      fb = 3'(k);
      step(2);
      chk("fb_sel", 9'(k), 9'(fbs));
    end
    fb = 3'h7;
    step(2);
    chk("fb_sel", 9'(FB_TEMP), 9'(fbs));
    for (int k = 0; k < 4; k++) begin
      bsel = 2'(k);
      ocw = 2'(k);
      step(2);
      chk("ballast", 9'(mask[k]), 9'(bal));
      chk("ocw", 9'(k), 9'({ocw_v, ocw_t}));
    end
    for (int k = 0; k < 4; k++) begin
      ot_high = k[1];
      temp = (k[1] ? OT_HIGH_C : OT_LOW_C) + 8'(k[0]);
      step(2);
      chk("ot_warn", 9'(k[0]), 9'(ot_warn));
    end
  endtask
  // counts at reference edges: ch0 on, ch1 on, both, strobe low
  // window of w reference edges, one period unless asked otherwise
  task automatic meas(input logic [8:0] e0, e1, eb, es, input int w = 256);
    logic [8:0] n0, n1, nb, ns;
    n0 = 0;
    n1 = 0;
    nb = 0;
    ns = 0;
    repeat (258) @(posedge ref_clk);
    repeat (w) begin
      @(posedge ref_clk);
      n0 += 9'(o_out[0] === 1'b1);
      n1 += 9'(o_out[1] === 1'b1);
      nb += 9'(o_out[1:0] === 2'b11);
      ns += 9'(strb_n === 1'b0);
    end
    step(1);
    chk("on_ch1", e0, n0);
    chk("on_ch2", e1, n1);
    chk("overlap", eb, nb);
    chk("strobe_low", es, ns);
  endtask
  task automatic t_pwm();
    d0 = 9'h000;
    meas(9'h000, 9'h080, 9'h000, 9'h000);
    d0 = 9'h100;
    meas(9'h100, 9'h080, 9'h080, 9'h000);
    d0 = 9'h080;
    sync = SYNC_VALID;
    fb = FB_CH1;
    meas(9'h080, 9'h080, 9'h000, 9'h080);
    sync = SYNC_TRIG_HALF;
    meas(9'h080, 9'h080, 9'h000, 9'h040);
    sync = SYNC_TRIG0;
    glob_sel = 5'h01;
    glob = 9'h0c8;
    d0 = 9'h00a;
    meas(9'h0c8, 9'h080, 9'h048, 9'h0c8);
    sync = SYNC_OFF;
    glob_sel = 5'h00;
    // two periods, so a skipped and a kept pulse both fall inside
    skip = 5'h01;
    d0 = 9'h002;
    meas(9'h004, 9'h100, 9'h000, 9'h000, 512);
    d0 = 9'h0fe;
    meas(9'h1fc, 9'h100, 9'h0fc, 9'h000, 512);
    skip = 5'h00;
  endtask
  task automatic t_bad();
    int n;
    n = 0;
    bad = 1'b1;
    while (fail !== 1'b1 && n < 80) begin
      step(1);
      n++;
    end
    bad = 1'b0;
    chk("fault", 9'h001, 9'(fault));
    for (int k = 0; k < 2; k++) begin
      di = k[0] ? 4'h5 : 4'ha;
      step(6);
      chk("out_fail", 9'(di), 9'(o_out));
    end
  endtask
  task automatic t_sleep();
    pin_n = 1'b0;
    step(6);
    chk("sleep", 9'h001, 9'(sleep));
    chk("reinit", 9'h000, 9'({fail, fault, rb_addr}));
    pin_n = 1'b1;
    step(6);
    chk("sleep", 9'h000, 9'(sleep));
    feed = 1'b1;
  endtask
  // last message may lie up to 32 cycles before feeding stops
  task automatic t_wd(input logic lg, input int lim);
    wd_long = lg;
    step(40);
    feed = 1'b0;
    step(lim - 40);
    chk("fail_early", 9'h000, 9'(fail));
    step(50);
    chk("fail_late", 9'h001, 9'(fail));
    t_sleep();
  endtask
  // hang guard, well beyond the expected run
  initial begin
    #400000;
    bad_count++;
    final_report();
  end
  initial begin
    i_rst = 1'b1;
    pin_n = 1'b1;
    {feed, bad, rb_wr, rb_rd, wd_long, rb_mode, ot_high} = 7'h00;
    {di, rb_sel, glob_sel, glob, d0} = 31'h0;
    {sync, bsel, ocw, fb, temp} = 17'h0;
    skip = 5'h00;
    step(20);
    chk("rst_out", 9'h003, 9'({o_out, sleep, strb_n}));
    i_rst = 1'b0;
    feed = 1'b1;
    step(6);
    chk("sleep", 9'h000, 9'(sleep));
    t_rb(1'b0);
    t_rb(1'b1);
    t_cfg();
    t_pwm();
    t_bad();
    t_sleep();
    t_wd(1'b0, 64);
    t_wd(1'b1, 256);
    final_report();
  end
endmodule
